//--- bwd_top.sv
// ==================================================================
// Board watchdog timer with APB register access
// ==================================================================
module bwd_top
    import bwd_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic wd_smi,
    output logic wd_irq_req,
    output logic board_reset_req,
    output logic pci_bus_rst_n,
    output logic watchdog_status_lamp
);

    bwd_regs_t r_reg;
    bwd_regs_t r_next;
    logic tick;
    logic tick_clr;
    logic setup;
    logic access;
    logic wr_ctrl;
    logic wr_service;
    logic rd_status;
    logic wr_mask;

    // ==============================================================
    // Bus phase decode
    // ==============================================================

    // The slave answers with no wait state: pready rises in the access
    // phase that follows the setup cycle, so every transfer takes two cycles.
    assign setup = psel && !penable;
    assign access = psel && penable && r_reg.pready;
    assign wr_ctrl = access && pwrite && (paddr == OFS_CTRL);
    assign wr_service = access && pwrite && (paddr == OFS_SERVICE);
    assign wr_mask = access && pwrite && (paddr == OFS_MASK);
    assign rd_status = access && !pwrite && (paddr == OFS_STATUS);

    // The divider restarts when a service or the enabling write loads the count,
    // so that the first base step after a service is a full one.
    assign tick_clr = (wr_service && r_reg.st == ST_RUN) ||
                      (wr_ctrl && !r_reg.en && pwdata[CTRL_EN_BIT]);

    bwd_tick_div #(
        .TICK_LEN(TICK_LEN)
    ) u_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(r_reg.st == ST_RUN),
        .clear(tick_clr),
        .tick(tick)
    );

    // ==============================================================
    // Next-state logic
    // ==============================================================

    // One process computes the whole next state: bus answers, control
    // fields, the countdown and the expiry actions.
    always_comb begin
        r_next = r_reg;
        r_next.pready = 1'b0;
        r_next.pslverr = 1'b0;
        r_next.smi = 1'b0;

        // Setup cycle: prepare the answer so it leaves a flip-flop.
        if (setup) begin
            r_next.pready = 1'b1;
            r_next.prdata = '0;
            unique case (paddr)
                OFS_CTRL: begin
                    r_next.prdata[CTRL_EN_BIT] = r_reg.en;
                    r_next.prdata[CTRL_ACT_LSB +: 2] = r_reg.act;
                    r_next.prdata[CTRL_SEL_LSB +: 4] = r_reg.sel;
                end
                OFS_SERVICE: begin
                    r_next.prdata = '0;
                end
                OFS_STATUS: begin
                    r_next.prdata[STS_W-1:0] = r_reg.sts;
                end
                OFS_MASK: begin
                    r_next.prdata[STS_W-1:0] = r_reg.mask;
                end
                OFS_COUNT: begin
                    r_next.prdata[REMAIN_W-1:0] = r_reg.remain;
                end
                default: begin
                    r_next.pslverr = 1'b1;
                end
            endcase
            if (pwrite) begin
                r_next.prdata = '0;
            end
        end

        // Reading the status register clears it; events below win.
        if (rd_status) begin
            r_next.sts = '0;
        end

        if (wr_mask) begin
            r_next.mask = pwdata[STS_W-1:0];
        end

        // Control writes are refused as a whole once enabled, so the
        // enable, action and timeout cannot be changed.
        if (wr_ctrl) begin
            if (r_reg.en) begin
                r_next.sts[STS_REFUSED_BIT] = 1'b1;
            end else begin
                r_next.act = pwdata[CTRL_ACT_LSB +: 2];
                r_next.sel = bwd_clamp_sel(pwdata[CTRL_SEL_LSB +: 4]);
                if (pwdata[CTRL_EN_BIT]) begin
                    r_next.en = 1'b1;
                    r_next.st = ST_RUN;
                    r_next.remain = bwd_ticks(bwd_clamp_sel(pwdata[CTRL_SEL_LSB +: 4]));
                end
            end
        end

        unique case (r_reg.st)
            ST_OFF: begin
                r_next.irq_req = 1'b0;
            end
            ST_RUN: begin
                // A service reloads the full timeout and drops the request.
                if (wr_service) begin
                    r_next.remain = bwd_ticks(r_reg.sel);
                    r_next.irq_req = 1'b0;
                end else if (tick) begin
                    if (r_reg.remain == REMAIN_W'(1)) begin
                        r_next.remain = bwd_ticks(r_reg.sel);
                        r_next.sts[STS_EXPIRED_BIT] = 1'b1;
                        case (r_reg.act)
                            ACT_SMI: begin
                                r_next.smi = 1'b1;
                            end
                            ACT_IRQ: begin
                                r_next.irq_req = 1'b1;
                            end
                            ACT_RST: begin
                                r_next.st = ST_RST;
                                r_next.brd_rst = 1'b1;
                                r_next.pci_rst_n = 1'b0;
                                r_next.hold = HOLD_W'(RST_HOLD_CYCLES - 1);
                            end
                            default: begin
                                // Reserved code: expiry is only recorded.
                            end
                        endcase
                    end else begin
                        r_next.remain = r_reg.remain - REMAIN_W'(1);
                    end
                end
            end
            ST_RST: begin
                // Hold the reset request, then wait for the board reset.
                if (r_reg.hold != '0) begin
                    r_next.hold = r_reg.hold - HOLD_W'(1);
                end else begin
                    r_next.brd_rst = 1'b0;
                    r_next.pci_rst_n = 1'b1;
                end
            end
        endcase

        // Level interrupt while any unmasked sticky bit is set.
        r_next.irq = |(r_next.sts & r_next.mask);
    end

    // ==============================================================
    // State register
    // ==============================================================

    // Only a board reset disables the watchdog again.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            r_reg.pready <= 1'b0;
            r_reg.pslverr <= 1'b0;
            r_reg.prdata <= 32'h0000_0000;
            r_reg.st <= ST_OFF;
            r_reg.en <= 1'b0;
            r_reg.act <= ACT_RESET_VAL;
            r_reg.sel <= SEL_RESET_VAL;
            r_reg.remain <= '0;
            r_reg.sts <= '0;
            r_reg.mask <= MASK_RESET_VAL;
            r_reg.irq <= 1'b0;
            r_reg.smi <= 1'b0;
            r_reg.irq_req <= 1'b0;
            r_reg.brd_rst <= 1'b0;
            r_reg.pci_rst_n <= 1'b1;
            r_reg.hold <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // ==============================================================
    // Outputs
    // ==============================================================

    // Every output is a bit of the state register.
    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.pslverr;
    assign irq = r_reg.irq;
    assign wd_smi = r_reg.smi;
    assign wd_irq_req = r_reg.irq_req;
    assign board_reset_req = r_reg.brd_rst;
    assign pci_bus_rst_n = r_reg.pci_rst_n;
    assign watchdog_status_lamp = r_reg.en;

endmodule

//--- bwd_pkg.sv

// ==================================================================
// Shared constants and types
// ==================================================================
package bwd_pkg;

    // Register byte offsets on the APB.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SERVICE = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0c;
    localparam logic [7:0] OFS_COUNT = 8'h10;

    // Control register field positions.
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_ACT_LSB = 1;
    localparam int CTRL_SEL_LSB = 4;

    // Status and mask bit positions.
    localparam int STS_EXPIRED_BIT = 0;
    localparam int STS_REFUSED_BIT = 1;
    localparam int STS_W = 2;

    // Reset values.
    localparam logic [1:0] ACT_RESET_VAL = 2'h0;
    localparam logic [3:0] SEL_RESET_VAL = 4'h0;
    localparam logic [1:0] MASK_RESET_VAL = 2'h0;

    // Timeout steps: the number of base steps doubles for each selector value.
    localparam logic [3:0] SEL_MAX = 4'hb;
    localparam int REMAIN_W = 12;

    // Timing: clock rate and the base step of the timeout.
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TICK_MS = 125;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int TICK_W = 22;

    // Board reset request pulse width.
    localparam int unsigned RST_HOLD_NS = 1000;
    localparam int unsigned RST_HOLD_CYCLES = RST_HOLD_NS / (1_000_000_000 / CLK_HZ);
    localparam int HOLD_W = 5;

    typedef enum logic [1:0] {
        ACT_SMI,
        ACT_IRQ,
        ACT_RST
    } bwd_action_t;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_RUN,
        ST_RST
    } bwd_state_t;

    // Whole state of the watchdog top.
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        bwd_state_t st;
        logic en;
        logic [1:0] act;
        logic [3:0] sel;
        logic [REMAIN_W-1:0] remain;
        logic [STS_W-1:0] sts;
        logic [STS_W-1:0] mask;
        logic irq;
        logic smi;
        logic irq_req;
        logic brd_rst;
        logic pci_rst_n;
        logic [HOLD_W-1:0] hold;
    } bwd_regs_t;

    // State of the base tick divider.
    typedef struct packed {
        logic [TICK_W-1:0] cnt;
        logic tick;
    } bwd_div_t;

    // Number of base ticks for a timeout selector.
    function automatic logic [REMAIN_W-1:0] bwd_ticks(input logic [3:0] sel);
        bwd_ticks = REMAIN_W'(1) << sel;
    endfunction

    // Out-of-range selectors are clamped to the longest timeout.
    function automatic logic [3:0] bwd_clamp_sel(input logic [3:0] sel);
        bwd_clamp_sel = (sel > SEL_MAX) ? SEL_MAX : sel;
    endfunction

endpackage

// ==================================================================
// Base tick divider
// ==================================================================
module bwd_tick_div
    import bwd_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic run,
    input wire logic clear,
    output logic tick
);

    bwd_div_t r_reg;
    bwd_div_t r_next;

    // Count only while running; a clear restarts a full base step.
    always_comb begin
        r_next = r_reg;
        r_next.tick = 1'b0;
        if (clear || !run) begin
            r_next.cnt = '0;
        end else if (r_reg.cnt == TICK_W'(TICK_LEN - 1)) begin
            r_next.cnt = '0;
            r_next.tick = 1'b1;
        end else begin
            r_next.cnt = r_reg.cnt + TICK_W'(1);
        end
    end

    // Synchronous reset register.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign tick = r_reg.tick;

endmodule

//--- bwd_top_asserts.sv
// ==================================================================
// Watchdog port checks
// ==================================================================
module bwd_top_asserts
    import bwd_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic wd_smi,
    input wire logic wd_irq_req,
    input wire logic board_reset_req,
    input wire logic pci_bus_rst_n,
    input wire logic watchdog_status_lamp
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [5:0] hold_cnt;
    logic en_wr;
    logic clr_acc;

    // Access decodes; only the access phase of a transfer has an effect.
    assign en_wr = psel && penable && pwrite && paddr == OFS_CTRL && pwdata[CTRL_EN_BIT];
    assign clr_acc = psel && penable && (paddr == OFS_STATUS || paddr == OFS_MASK);

    // Counts how long the board reset request has stood, to check its width.
    always_ff @(posedge clk_sys) begin
        if (rst || !board_reset_req) begin
            hold_cnt <= 6'h00;
        end else begin
            hold_cnt <= hold_cnt + 6'h01;
        end
    end

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_service;
        psel && penable && pwrite && paddr == OFS_SERVICE && wd_irq_req;
    endsequence

    a_bus_answer: assert property (s_setup |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_lamp_cause: assert property ($rose(watchdog_status_lamp) |-> $past(en_wr) || $past(en_wr, 2))
        else $error("lamp rose without enable");
    a_lamp_held: assert property (watchdog_status_lamp |=> watchdog_status_lamp)
        else $error("watchdog stopped");
    a_action_enabled: assert property ((wd_smi || wd_irq_req || board_reset_req) |-> watchdog_status_lamp)
        else $error("action while disabled");
    a_one_action: assert property ($onehot0({wd_smi, $rose(wd_irq_req), $rose(board_reset_req)}))
        else $error("several actions at once");
    a_smi_gap: assert property (wd_smi |=> !wd_smi [*7])
        else $error("expiries too close");
    a_reset_pair: assert property (board_reset_req == !pci_bus_rst_n)
        else $error("bus reset not paired");
    a_reset_width: assert property ($fell(board_reset_req) |-> hold_cnt == RST_HOLD_CYCLES)
        else $error("reset pulse width wrong");
    a_service_clear: assert property (s_service |=> ##[0:1] !wd_irq_req)
        else $error("service left request up");
    a_irq_drop: assert property ($fell(irq) |-> $past(clr_acc) || $past(clr_acc, 2))
        else $error("irq fell without read or mask");
endmodule

bind bwd_top bwd_top_asserts #(.TICK_LEN(TICK_LEN)) u_chk (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .wd_smi(wd_smi),
    .wd_irq_req(wd_irq_req), .board_reset_req(board_reset_req),
    .pci_bus_rst_n(pci_bus_rst_n), .watchdog_status_lamp(watchdog_status_lamp));

//--- bwd_top_tb.sv
// ==================================================================
// Watchdog testbench
// ==================================================================
module bwd_top_tb
    import bwd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TL = 8;
    typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] rd; logic er;} bwd_row_t;
    logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq, er;
    logic wd_smi, wd_irq_req, board_reset_req, pci_bus_rst_n, watchdog_status_lamp;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int err_count, n_checks, n;
    // Register rows: writes, readbacks, idle count, clamped selector and unmapped places.
    bwd_row_t rows [9] = '{'{1'b1, OFS_MASK, 32'h3, 32'h0, 1'b0},
        '{1'b0, OFS_MASK, 32'h0, 32'h3, 1'b0}, '{1'b0, OFS_CTRL, 32'h0, 32'h0, 1'b0},
        '{1'b0, OFS_STATUS, 32'h0, 32'h0, 1'b0}, '{1'b0, OFS_COUNT, 32'h0, 32'h0, 1'b0},
        '{1'b1, OFS_CTRL, 32'hf2, 32'h0, 1'b0}, '{1'b0, OFS_CTRL, 32'h0, 32'hb2, 1'b0},
        '{1'b0, 8'h14, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h40, 32'h5, 32'h0, 1'b1}};

    bwd_top #(.TICK_LEN(TL)) uut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .wd_smi(wd_smi), .wd_irq_req(wd_irq_req),
        .board_reset_req(board_reset_req), .pci_bus_rst_n(pci_bus_rst_n),
        .watchdog_status_lamp(watchdog_status_lamp));

    // Free running 20 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h got %h", nm, exp, got);
        end
    endtask

    // One APB transfer; the request stands until pready is seen high at a rising edge.
    // Values read just after an edge are the ones that edge sampled, because the design
    // only updates its flip-flops by non-blocking assignment.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) begin
                rd = prdata;
                er = pslverr;
                break;
            end
        end
        if (i == 20) begin
            check("pready", 1, 0);
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reset is held for eight clock cycles.
    task automatic do_reset();
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
    endtask

    function automatic logic ev(input int k);
        return (k == 0) ? wd_smi : (k == 1) ? wd_irq_req : board_reset_req;
    endfunction

    // Bounded wait for an expiry action, counting falling edges.
    task automatic wait_ev(input int k, input int lim);
        n = 0;
        while (ev(k) !== 1'b1) begin
            if (n >= lim) begin
                check("action", 1, 0);
                complete_run();
            end
            @(negedge clk_sys);
            n++;
        end
    endtask

    // Enable with each action, try to stop it, then let it expire.
    task automatic run_action(input int k);
        do_reset();
        apb(1, OFS_MASK, 32'h1);
        apb(1, OFS_CTRL, 32'h11 | (32'(k) << 1));
        @(negedge clk_sys);
        check("lamp", 1, 32'(watchdog_status_lamp));
        apb(1, OFS_CTRL, 32'h0);
        apb(0, OFS_CTRL, 0);
        check("ctrl", 32'h11 | (32'(k) << 1), rd);
        apb(0, OFS_STATUS, 0);
        check("refused", 2, rd);
        wait_ev(k, 100);
        check("smi", 32'(k == 0), 32'(wd_smi));
        check("irq_req", 32'(k == 1), 32'(wd_irq_req));
        check("bus_rst_n", 32'(k != 2), 32'(pci_bus_rst_n));
        check("irq", 1, 32'(irq));
        if (k == 0) begin
            @(negedge clk_sys);
            wait_ev(0, 100);
            check("period", TL * 2, n + 1);
            apb(0, OFS_STATUS, 0);
            check("status", 1, rd);
            repeat (2) @(negedge clk_sys);
            check("irq clr", 0, 32'(irq));
            apb(1, OFS_MASK, 0);
            wait_ev(0, 100);
            @(negedge clk_sys);
            check("irq masked", 0, 32'(irq));
            apb(1, OFS_MASK, 1);
            repeat (2) @(negedge clk_sys);
            check("irq unmask", 1, 32'(irq));
        end else if (k == 1) begin
            repeat (4) begin
                apb(1, OFS_SERVICE, 0);
                repeat (6) @(negedge clk_sys);
                check("serviced", 0, 32'(wd_irq_req));
            end
            apb(1, OFS_SERVICE, 0);
            wait_ev(1, 100);
            // The registered base tick puts expiry one cycle after the last full step.
            check("reload", TL * 2 + 1, n - 1);
        end else begin
            n = 0;
            while (board_reset_req === 1'b1 && n < 100) begin
                @(negedge clk_sys);
                n++;
            end
            check("hold", RST_HOLD_CYCLES, n);
            check("bus_rst_n", 1, 32'(pci_bus_rst_n));
        end
        $display("test action %0d done", k);
    endtask

    // Main sequence: register rows, then hand-written cases.
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        err_count = 0;
        n_checks = 0;
        do_reset();
        check("lamp rst", 0, 32'(watchdog_status_lamp));
        check("bus rst", 1, 32'(pci_bus_rst_n));
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            check("rdata", rows[i].rd, rd);
            check("pslverr", 32'(rows[i].er), 32'(er));
        end
        $display("test registers done");
        for (int k = 0; k < 3; k++) run_action(k);
        do_reset();
        apb(1, OFS_CTRL, 32'hb1);
        wait_ev(0, 20000);
        check("longest", TL * 2048 + 1, n - 1);
        $display("test longest done");
        complete_run();
    end
endmodule
